/* File: common/exception_priority_pkg.sv */
/*
 * Shared constants for the exception priority and latching block:
 * register offsets, field positions, reset values and vector addresses.
 * Assumes a 32-bit AXI4-Lite register bus and a 16-bit vector space.
 */
package exception_priority_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_PRIO_SEL = 8'h04;
   localparam logic [7:0] OFF_ENABLE = 8'h08;
   localparam logic [7:0] OFF_FLAGS  = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;

   // Control register field positions
   localparam int CTRL_GMASK_BIT = 0;
   localparam int CTRL_XMASK_BIT = 1;
   localparam int CTRL_EDGE_BIT  = 2;

   // Status register field positions
   localparam int STAT_PEND_BIT  = 16;

   // Reset values
   localparam logic       GMASK_RST  = 1'b1;
   localparam logic       XMASK_RST  = 1'b1;
   localparam logic       EDGE_RST   = 1'b0;
   localparam logic [7:0] PRIO_SEL_RST = 8'hF2;

   // Vector addresses, highest first
   localparam logic [15:0] VEC_RESET  = 16'hFFFE;
   localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
   localparam logic [15:0] VEC_WDOG   = 16'hFFFA;
   localparam logic [15:0] VEC_TRAP   = 16'hFFF8;
   localparam logic [15:0] VEC_SOFT_INT = 16'hFFF6;
   localparam logic [15:0] VEC_NMI    = 16'hFFF4;
   localparam logic [15:0] VEC_MASK0  = 16'hFFF2;
   localparam logic [15:0] VEC_FLOOR  = 16'hFF80;
   localparam logic [7:0]  PRIO_SEL_TOP = 8'hF2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* File: logic/exception_priority_latching.sv */
/*
 * Exception priority and latching block: orders reset, non-maskable and
 * maskable requests and hands the core the vector address to fetch.
 * Assumes request inputs synchronous to aclk, a core that pulses
 * svc_start to begin a service sequence, and an AXI4-Lite master.
 */
// Contract
// - Each source has its own 16-bit vector
// - Vectors lie in top 128 bytes
// - Six highest vectors: resets and non-maskables
// - Fixed non-maskable order, reset pin first
// - Pin NMI taken only while X clear
// - Maskable requests need global mask clear
// - Global mask resets to one, writable
// - One maskable source promotable, rest default
// - Promoted source still masked, vector unchanged
// - Priority select written only while masked
// - NMI pin level; external pin level/edge
// - Vanished request at service gives trap
// - Edge latch held, cleared on service
// - Other maskable requests latched in flags
// - Edge select one: falling edges only
module exception_priority_latching #(
   parameter int N_MASK = 32
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Request sources
   input  wire logic              reset_req,
   input  wire logic              clock_monitor_req,
   input  wire logic              watchdog_reset,
   input  wire logic              unimpl_trap_req,
   input  wire logic              software_interrupt_instr,
   input  wire logic              nonmaskable_int_pin_n,
   input  wire logic              ext_int_pin_n,
   input  wire logic [N_MASK-1:0] periph_set,
   // Core side
   input  wire logic              svc_start,
   output logic                   int_pending,
   output logic                   vec_valid,
   output logic [15:0]            vec_addr
);

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              aw_have;
      logic              w_have;
      logic [7:0]        awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic              gmask;
      logic              xmask;
      logic              edge_sel;
      logic [7:0]        prio_sel;
      logic [N_MASK-1:0] enable;
      logic [N_MASK-1:0] flags;
      logic              ext_pin_q;
      logic              edge_latch;
      logic              int_pending;
      logic              vec_valid;
      logic [15:0]       vec_addr;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Byte-lane merge of a write into a 32-bit register image
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = data[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Vector of maskable source k: two bytes per step below the top
   function automatic logic [15:0] mask_vec(input int k);
      return 16'(exception_priority_pkg::VEC_MASK0 - 16'(2 * k));
   endfunction

   // Extended views of the narrow maskable registers
   logic [31:0] enable_ext;
   logic [31:0] flags_ext;
   logic [31:0] merged;
   assign enable_ext = 32'(s_q.enable);
   assign flags_ext  = 32'(s_q.flags);

   // Active maskable requests before masking
   logic [N_MASK-1:0] active;
   logic [N_MASK-1:0] pend;
   logic              ext_level;
   logic              ext_fall;
   assign ext_level = ~ext_int_pin_n;
   assign ext_fall  = s_q.ext_pin_q & ~ext_int_pin_n;

   always_comb begin
      active    = s_q.flags;
      active[0] = s_q.edge_sel ? s_q.edge_latch : ext_level;
      pend      = s_q.gmask ? '0 : (active & s_q.enable);
   end

   // Maskable winner: promoted source first, else lowest index
   logic        mask_hit;
   logic [15:0] mask_sel;
   logic        sel_irq;
   logic [15:0] cand;
   always_comb begin
      mask_hit = 1'b0;
      mask_sel = exception_priority_pkg::VEC_TRAP;
      sel_irq  = 1'b0;
      cand     = 16'h0000;
      for (int k = N_MASK - 1; k >= 0; k--) begin
         if (pend[k]) begin
            mask_hit = 1'b1;
            mask_sel = mask_vec(k);
            sel_irq  = (k == 0);
         end
      end
      for (int k = 0; k < N_MASK; k++) begin
         cand = mask_vec(k);
         if (pend[k] && cand[7:0] == s_q.prio_sel) begin
            mask_sel = mask_vec(k);
            sel_irq  = (k == 0);
         end
      end
   end

   // Whole-block winner; non-maskables in fixed order
   logic        any_req;
   logic [15:0] win_vec;
   logic        nmi_req;
   assign nmi_req = ~nonmaskable_int_pin_n & ~s_q.xmask;

   always_comb begin
      any_req = 1'b1;
      if (reset_req) begin
         win_vec = exception_priority_pkg::VEC_RESET;
      end else if (clock_monitor_req) begin
         win_vec = exception_priority_pkg::VEC_CLKMON;
      end else if (watchdog_reset) begin
         win_vec = exception_priority_pkg::VEC_WDOG;
      end else if (unimpl_trap_req) begin
         win_vec = exception_priority_pkg::VEC_TRAP;
      end else if (software_interrupt_instr) begin
         win_vec = exception_priority_pkg::VEC_SOFT_INT;
      end else if (nmi_req) begin
         win_vec = exception_priority_pkg::VEC_NMI;
      end else begin
         any_req = mask_hit;
         win_vec = mask_sel;
      end
   end

   // Next state
   logic        do_write;
   logic        wr_err;
   logic [31:0] rd_val;
   logic        rd_err;
   logic        serve_irq;
   always_comb begin
      s_d       = s_q;
      merged    = 32'h0000_0000;
      wr_err    = 1'b0;
      rd_val    = 32'h0000_0000;
      rd_err    = 1'b0;
      serve_irq = 1'b0;

      // Pin history for falling-edge detection
      s_d.ext_pin_q   = ext_int_pin_n;
      s_d.int_pending = any_req;
      s_d.vec_valid   = 1'b0;

      // Write address and data taken in either order
      if (s_q.awready && s_axi_awvalid) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
         s_d.awready = 1'b0;
      end
      if (s_q.wready && s_axi_wvalid) begin
         s_d.w_have = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstrb  = s_axi_wstrb;
         s_d.wready = 1'b0;
      end
      do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;

      // Service sequence start; hardware masks while the handler runs
      if (svc_start) begin
         s_d.vec_valid = 1'b1;
         s_d.vec_addr  = any_req ? win_vec : exception_priority_pkg::VEC_TRAP;
         s_d.gmask     = 1'b1;
         if (win_vec == exception_priority_pkg::VEC_NMI && any_req) begin
            s_d.xmask = 1'b1;
         end
         serve_irq = any_req && sel_irq && (win_vec == mask_sel);
      end

      // Register writes
      if (do_write) begin
         unique case (s_q.awaddr)
            exception_priority_pkg::OFF_CTRL: begin
               merged = merge({29'h0, s_q.edge_sel, s_q.xmask, s_q.gmask},
                              s_q.wdata, s_q.wstrb);
               s_d.gmask    = merged[exception_priority_pkg::CTRL_GMASK_BIT];
               s_d.xmask    = merged[exception_priority_pkg::CTRL_XMASK_BIT];
               s_d.edge_sel = merged[exception_priority_pkg::CTRL_EDGE_BIT];
            end
            exception_priority_pkg::OFF_PRIO_SEL: begin
               if (s_q.gmask && s_q.wstrb[0]) begin
                  s_d.prio_sel = s_q.wdata[7:0];
               end
            end
            exception_priority_pkg::OFF_ENABLE: begin
               merged     = merge(enable_ext, s_q.wdata, s_q.wstrb);
               s_d.enable = merged[N_MASK-1:0];
            end
            exception_priority_pkg::OFF_FLAGS: begin
               merged    = merge(32'h0000_0000, s_q.wdata, s_q.wstrb);
               s_d.flags = s_q.flags & ~merged[N_MASK-1:0];
            end
            exception_priority_pkg::OFF_STATUS: begin
            end
            default: wr_err = 1'b1;
         endcase
         s_d.bvalid = 1'b1;
         s_d.bresp  = wr_err ? exception_priority_pkg::RESP_SLVERR
                             : exception_priority_pkg::RESP_OKAY;
      end

      // Write response retires; channels reopen together
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid  = 1'b0;
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.awready = 1'b1;
         s_d.wready  = 1'b1;
      end

      // Peripheral events set flags; set wins over a same-cycle clear
      s_d.flags    = s_d.flags | periph_set;
      s_d.flags[0] = 1'b0;

      // Edge latch: cleared by service, a new edge in that cycle wins
      // Armed only in edge mode, so a level-mode dip leaves no stale request
      if (serve_irq && s_q.edge_sel) begin
         s_d.edge_latch = 1'b0;
      end
      if (ext_fall && s_q.edge_sel) begin
         s_d.edge_latch = 1'b1;
      end

      // Register reads
      if (s_q.arready && s_axi_arvalid) begin
         unique case (s_axi_araddr)
            exception_priority_pkg::OFF_CTRL:
               rd_val = {29'h0, s_q.edge_sel, s_q.xmask, s_q.gmask};
            exception_priority_pkg::OFF_PRIO_SEL: rd_val = {24'h0, s_q.prio_sel};
            exception_priority_pkg::OFF_ENABLE: rd_val = enable_ext;
            exception_priority_pkg::OFF_FLAGS:  rd_val = flags_ext;
            exception_priority_pkg::OFF_STATUS: begin
               rd_val = {s_q.vec_addr, 16'h0000};
               rd_val = {rd_val[31:16], s_q.vec_addr};
               rd_val[exception_priority_pkg::STAT_PEND_BIT] = s_q.int_pending;
               rd_val[31:17] = 15'h0000;
            end
            default: rd_err = 1'b1;
         endcase
         s_d.arready = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rdata   = rd_val;
         s_d.rresp   = rd_err ? exception_priority_pkg::RESP_SLVERR
                              : exception_priority_pkg::RESP_OKAY;
      end
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q          <= '0;
         s_q.awready  <= 1'b1;
         s_q.wready   <= 1'b1;
         s_q.arready  <= 1'b1;
         s_q.gmask    <= exception_priority_pkg::GMASK_RST;
         s_q.xmask    <= exception_priority_pkg::XMASK_RST;
         s_q.edge_sel <= exception_priority_pkg::EDGE_RST;
         s_q.prio_sel <= exception_priority_pkg::PRIO_SEL_RST;
         s_q.enable   <= {{(N_MASK-1){1'b0}}, 1'b1};
         s_q.ext_pin_q <= 1'b1;
         s_q.vec_addr <= exception_priority_pkg::VEC_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Every output straight from the state register
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready  = s_q.wready;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign int_pending   = s_q.int_pending;
   assign vec_valid     = s_q.vec_valid;
   assign vec_addr      = s_q.vec_addr;

endmodule // exception_priority_latching

/* File: tb/exception_priority_latching_sva.sv */
/* Checker for the exception priority block: service answer and bus holds.
   Assumes binding to the top module and one clock, aclk. */
module epl_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        reset_req,
   input wire logic        clock_monitor_req,
   input wire logic        watchdog_reset,
   input wire logic        unimpl_trap_req,
   input wire logic        svc_start,
   input wire logic        int_pending,
   input wire logic        vec_valid,
   input wire logic [15:0] vec_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Service answer comes one cycle after the start pulse
   AST_VEC_PULSE: assert property (svc_start |=> vec_valid)
      else $error("no vector after service start");
   AST_VEC_QUIET: assert property (!svc_start |=> !vec_valid && $stable(vec_addr))
      else $error("vector moved without service start");
   // Fixed order among the held resets and traps
   AST_TOP_RESET: assert property (svc_start && reset_req |=> vec_addr == 16'hFFFE)
      else $error("reset request not served first");
   AST_CLKMON: assert property (
      svc_start && !reset_req && clock_monitor_req |=> vec_addr == 16'hFFFC)
      else $error("clock monitor order wrong");
   AST_WDOG: assert property (
      svc_start && !reset_req && !clock_monitor_req && watchdog_reset
      |=> vec_addr == 16'hFFFA)
      else $error("watchdog order wrong");
   AST_UNIMPL: assert property (
      svc_start && !reset_req && !clock_monitor_req && !watchdog_reset && unimpl_trap_req
      |=> vec_addr == 16'hFFF8)
      else $error("trap order wrong");
   AST_RANGE: assert property (vec_valid |-> vec_addr >= 16'hFF80 && !vec_addr[0])
      else $error("vector outside top block");
   AST_NM_PEND: assert property (reset_req |=> int_pending)
      else $error("reset request not pending");
   // Responses hold while the master stalls
   AST_BHOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RHOLD: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule // epl_checker

bind exception_priority_latching epl_checker chk_i (.aclk, .aresetn, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .reset_req,
   .clock_monitor_req, .watchdog_reset, .unimpl_trap_req, .svc_start, .int_pending,
   .vec_valid, .vec_addr);

/* File: tb/core_side_model.sv */
/* Core side model: starts a service sequence when told to.
   Assumes the bench pulses go once per service, on aclk. */
module core_side_model (
   input  wire logic       aclk,
   input  wire logic       go,
   input  wire logic       blind,
   input  wire logic [2:0] lag,
   input  wire logic       int_pending,
   output logic            svc_start
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       armed = 1'b0;
   logic [2:0] cnt = 3'h0;
   // Blind start mimics a core already committed when the request left
   // Start strobe written once per edge, never lowered and raised together
   always @(posedge aclk) begin
      if (go) begin
         armed     <= 1'b1;
         cnt       <= lag;
         svc_start <= 1'b0;
      end else if (armed && (int_pending || blind) && cnt == 3'h0) begin
         svc_start <= 1'b1;
         armed     <= 1'b0;
      end else begin
         svc_start <= 1'b0;
         if (armed && (int_pending || blind)) begin
            cnt <= cnt - 3'h1;
         end
      end
   end
endmodule // core_side_model

/* File: tb/tb_exception_priority_latching.sv */
/* Bench for the exception priority block: bus, pins and core service.
   Assumes the package offsets and a 32-source build. */
module tb_exception_priority_latching;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, blind;
   logic        awready, wready, bvalid, arready, rvalid, int_pending, vec_valid, svc_start;
   logic        nmi_n, ext_n;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, periph, s;
   logic [1:0]  bresp, rresp;
   logic [4:0]  nm;
   logic [2:0]  lag;
   logic [15:0] vec_addr;
   logic [33:0] vq[$], rq[$], bq[$];
   int          n_fail = 0, tests_run = 0;

   exception_priority_latching #(.N_MASK(32)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .reset_req(nm[0]), .clock_monitor_req(nm[1]), .watchdog_reset(nm[2]),
      .unimpl_trap_req(nm[3]), .software_interrupt_instr(nm[4]),
      .nonmaskable_int_pin_n(nmi_n), .ext_int_pin_n(ext_n), .periph_set(periph),
      .svc_start(svc_start), .int_pending(int_pending), .vec_valid(vec_valid),
      .vec_addr(vec_addr));
   core_side_model core (.aclk(aclk), .go(go), .blind(blind), .lag(lag),
      .int_pending(int_pending), .svc_start(svc_start));

   always #5 aclk = ~aclk;

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Scoreboard: oldest note against each result as it shows
   always @(posedge aclk) begin
      if (vec_valid === 1'b1) begin
         chk({18'h0, vec_addr}, vq.size() ? vq.pop_front() : 34'hX);
      end
      if (rvalid === 1'b1 && rready) begin
         chk({rresp, rdata}, rq.size() ? rq.pop_front() : 34'hX);
      end
      if (bvalid === 1'b1 && bready) begin
         chk({32'h0, bresp}, bq.size() ? bq.pop_front() : 34'hX);
      end
   end

   // Write: both channels offered together, response stalled briefly
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = exception_priority_pkg::RESP_OKAY);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      bq.push_back({32'h0, e});
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (!ta && awready) awvalid <= 1'b0;
         if (!tw && wready) wvalid <= 1'b0;
         ta = ta | awready;
         tw = tw | wready;
      end
      repeat (3) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask

   // Read: one stall cycle so the data hold is exercised
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = exception_priority_pkg::RESP_OKAY);
      rq.push_back({e, d});
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask

   task automatic ctl(input logic [31:0] d);
      wr(exception_priority_pkg::OFF_CTRL, d);
   endtask

   // Service with a random core delay
   task automatic svc(input logic [15:0] v, input logic b = 1'b0);
      vq.push_back({18'h0, v});
      s = lfsr(s);
      lag   <= s[2:0];
      blind <= b;
      go    <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do @(posedge aclk); while (vec_valid !== 1'b1);
   endtask

   task automatic pulse(input logic [31:0] p);
      periph <= p;
      @(posedge aclk);
      periph <= 32'h0;
   endtask

   // Hang guard, well beyond the expected run
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      stop_test();
   end

   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, blind} = 9'h0;
      {awaddr, araddr, wdata, periph, nm, lag} = 88'h0;
      {nmi_n, ext_n} = 2'h3;
      s = 32'h5C3C;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(exception_priority_pkg::OFF_CTRL, 32'h3);
      rd(exception_priority_pkg::OFF_PRIO_SEL, 32'hF2);
      rd(exception_priority_pkg::OFF_ENABLE, 32'h1);
      rd(exception_priority_pkg::OFF_FLAGS, 32'h0);
      for (int i = 0; i < 5; i++) begin
         nm <= 5'h1F << i;
         svc(16'hFFFE - 16'(2 * i));
      end
      nm <= 5'h0;
      ctl(32'h1);
      nmi_n <= 1'b0;
      svc(16'hFFF4);
      svc(16'hFFF8, 1'b1);
      nmi_n <= 1'b1;
      ctl(32'h6);
      ext_n <= 1'b0;
      svc(16'hFFF2);
      ctl(32'h6);
      svc(16'hFFF8, 1'b1);
      ext_n <= 1'b1;
      ctl(32'h2);
      ext_n <= 1'b0;
      svc(16'hFFF2);
      ext_n <= 1'b1;
      ctl(32'h2);
      svc(16'hFFF8, 1'b1);
      ctl(32'h2);
      wr(exception_priority_pkg::OFF_ENABLE, 32'hFFFF_FFFF);
      pulse(32'h28);
      svc(16'hFFEC);
      ctl(32'h2);
      svc(16'hFFEC);
      wr(exception_priority_pkg::OFF_FLAGS, 32'h8);
      ctl(32'h2);
      svc(16'hFFE8);
      rd(exception_priority_pkg::OFF_STATUS, 32'h0000_FFE8);
      wr(exception_priority_pkg::OFF_FLAGS, 32'h20);
      pulse(32'h28);
      ctl(32'h2);
      wr(exception_priority_pkg::OFF_PRIO_SEL, 32'hE8);
      rd(exception_priority_pkg::OFF_PRIO_SEL, 32'hF2);
      ctl(32'h3);
      wr(exception_priority_pkg::OFF_PRIO_SEL, 32'hE8);
      rd(exception_priority_pkg::OFF_PRIO_SEL, 32'hE8);
      ctl(32'h2);
      svc(16'hFFE8);
      wr(exception_priority_pkg::OFF_ENABLE, 32'hFFFF_FFDF);
      ctl(32'h2);
      svc(16'hFFEC);
      wr(exception_priority_pkg::OFF_FLAGS, 32'h28);
      rd(exception_priority_pkg::OFF_STATUS, 32'h0000_FFEC);
      s = lfsr(s);
      wr(exception_priority_pkg::OFF_ENABLE, s);
      rd(exception_priority_pkg::OFF_ENABLE, s);
      wr(8'h14, 32'h1, exception_priority_pkg::RESP_SLVERR);
      rd(8'h14, 32'h0, exception_priority_pkg::RESP_SLVERR);
      stop_test();
   end
endmodule // tb_exception_priority_latching
